// *** rtl/aln_defines.svh ***
// Summary of operation
// - Conversion low bits go to accumulator high bits
// - Same instruction clears accumulator bits one, zero
// - Memory toggle instruction loads accumulator from memory
// - Then page select takes XOR with immediate
// - Six fixed upper bits, four immediate bits
// - Clock control copied whole, left unchanged
`ifndef ALN_DEFINES_SVH
`define ALN_DEFINES_SVH

// ***************************************************************
// Register map (byte addresses on the bus)
// ***************************************************************
`define ALN_ADR_INSTR     8'h00
`define ALN_ADR_ACC       8'h04
`define ALN_ADR_PAGE      8'h08
`define ALN_ADR_CONV      8'h0c
`define ALN_ADR_CLKCTRL   8'h10
`define ALN_ADR_PTR       8'h14
`define ALN_ADR_MEMDATA   8'h18
`define ALN_ADR_STATUS    8'h1c
`define ALN_ADR_COUNT     8'h20

// ***************************************************************
// Widths
// ***************************************************************
`define ALN_ADR_W         8
`define ALN_DAT_W         32
`define ALN_SEL_W         4
`define ALN_INSTR_W       10
`define ALN_NIB_W         4
`define ALN_CONV_W        10
`define ALN_PTR_W         8
`define ALN_MEM_DEPTH     256
`define ALN_CNT_W         16

// ***************************************************************
// Instruction encodings
// ***************************************************************
`define ALN_OPC_CONV_LOW  10'h249
`define ALN_OPC_CLK_READ  10'h252
`define ALN_OPC_MEM_HI    6'h2c
`define ALN_OPC_HI_MSB    9
`define ALN_OPC_HI_LSB    4
`define ALN_IMM_MSB       3
`define ALN_IMM_LSB       0
`define ALN_LOW_ZERO      2'h0

// ***************************************************************
// Status fields and reset values
// ***************************************************************
`define ALN_ST_UNKNOWN    0
`define ALN_ST_CARRY      1
`define ALN_ST_LASTOP_LSB 4
`define ALN_ST_LASTOP_MSB 5
`define ALN_RST_NIB       4'h0
`define ALN_RST_INSTR     10'h000
`define ALN_RST_CONV      10'h000
`define ALN_RST_PTR       8'h00
`define ALN_RST_CNT       16'h0000
`define ALN_RST_DAT       32'h0000_0000
`define ALN_CNT_ONE       16'h0001

`endif

// *** rtl/aln_pkg.sv ***
`include "aln_defines.svh"

package aln_pkg;

   // ***************************************************************
   // Decoded operation classes
   // ***************************************************************
   typedef enum logic [1:0] {
      ALN_OP_NONE       = 2'b00,
      ALN_OP_CONV_LOW   = 2'b01,
      ALN_OP_MEM_TOGGLE = 2'b10,
      ALN_OP_CLK_READ   = 2'b11
   } aln_op_e;

   typedef logic [`ALN_NIB_W-1:0] aln_nib_t;

   // ***************************************************************
   // Whole state of the core
   // ***************************************************************
   typedef struct packed {
      logic                                   ack;
      logic [`ALN_DAT_W-1:0]                  dat;
      logic [`ALN_INSTR_W-1:0]                instr;
      aln_nib_t                               acc;
      aln_nib_t                               page;
      logic [`ALN_CONV_W-1:0]                 conv;
      aln_nib_t                               clk_ctrl;
      logic [`ALN_PTR_W-1:0]                  ptr;
      logic                                   carry;
      logic                                   unknown;
      aln_op_e                                last_op;
      logic [`ALN_CNT_W-1:0]                  count;
      logic [`ALN_MEM_DEPTH-1:0][`ALN_NIB_W-1:0] mem;
   } aln_state_s;

endpackage

// *** rtl/aln_dec_if.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "aln_defines.svh"

// Instruction word out to the decoder, operation class and immediate back
interface aln_dec_if;
   logic [`ALN_INSTR_W-1:0] word;
   aln_pkg::aln_op_e        op;
   aln_pkg::aln_nib_t       imm;

   modport core (output word, input op, input imm);
   modport dec  (input word, output op, output imm);
endinterface

`default_nettype wire

// *** rtl/aln_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "aln_defines.svh"

module aln_decoder (
   aln_dec_if.dec dec
);

   // ***************************************************************
   // Opcode match; purely combinational so execution fits one cycle
   // ***************************************************************
   always_comb begin
      dec.imm = dec.word[`ALN_IMM_MSB:`ALN_IMM_LSB];
      if (dec.word == `ALN_OPC_CONV_LOW) begin
         dec.op = aln_pkg::ALN_OP_CONV_LOW;
      end else if (dec.word == `ALN_OPC_CLK_READ) begin
         dec.op = aln_pkg::ALN_OP_CLK_READ;
      end else if (dec.word[`ALN_OPC_HI_MSB:`ALN_OPC_HI_LSB] == `ALN_OPC_MEM_HI) begin
         dec.op = aln_pkg::ALN_OP_MEM_TOGGLE;
      end else begin
         dec.op = aln_pkg::ALN_OP_NONE;
      end
   end

endmodule

`default_nettype wire

// *** rtl/aln_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "aln_defines.svh"

module aln_core (
   input  wire logic                  CORE_CLK,
   input  wire logic                  NRST,
   input  wire logic                  WB_CYC_I,
   input  wire logic                  WB_STB_I,
   input  wire logic                  WB_WE_I,
   input  wire logic [`ALN_ADR_W-1:0] WB_ADR_I,
   input  wire logic [`ALN_SEL_W-1:0] WB_SEL_I,
   input  wire logic [`ALN_DAT_W-1:0] WB_DAT_I,
   output var  logic [`ALN_DAT_W-1:0] WB_DAT_O,
   output var  logic                  WB_ACK_O
);

   // ***************************************************************
   // State and decoder hookup
   // ***************************************************************
   aln_pkg::aln_state_s     state_reg;
   aln_pkg::aln_state_s     state_next;
   logic [`ALN_DAT_W-1:0]   wr_mask;
   logic [`ALN_DAT_W-1:0]   rd_word;
   logic [`ALN_INSTR_W-1:0] instr_merged;
   logic                    req;
   logic                    wr;
   logic                    instr_wr;

   aln_dec_if dec_bus ();

   aln_decoder u_decoder (
      .dec (dec_bus)
   );

   // ***************************************************************
   // Bus qualifiers
   // ***************************************************************
   // A request is taken once; ack drops the cycle after it was given
   assign req = WB_CYC_I && WB_STB_I && !state_reg.ack;
   assign wr  = req && WB_WE_I;

   // Byte lane mask built from the select lines
   genvar lane;
   generate
      for (lane = 0; lane < `ALN_SEL_W; lane = lane + 1) begin : g_lane
         assign wr_mask[lane*8 +: 8] = {8{WB_SEL_I[lane]}};
      end
   endgenerate

   // Instruction word as it will stand after this write
   assign instr_merged = (state_reg.instr & ~wr_mask[`ALN_INSTR_W-1:0])
                       | (WB_DAT_I[`ALN_INSTR_W-1:0] & wr_mask[`ALN_INSTR_W-1:0]);

   // Only a write touching the low lane issues an instruction
   assign instr_wr = wr && (WB_ADR_I == `ALN_ADR_INSTR) && WB_SEL_I[0];

   // Decoder sees the word being issued, so it executes in that cycle
   assign dec_bus.word = instr_merged;

   // ***************************************************************
   // Read multiplexer
   // ***************************************************************
   // Unmapped and unaligned addresses read as zero
   always_comb begin
      rd_word = `ALN_RST_DAT;
      case (WB_ADR_I)
         `ALN_ADR_INSTR: begin
            rd_word[`ALN_INSTR_W-1:0] = state_reg.instr;
         end
         `ALN_ADR_ACC: begin
            rd_word[`ALN_NIB_W-1:0] = state_reg.acc;
         end
         `ALN_ADR_PAGE: begin
            rd_word[`ALN_NIB_W-1:0] = state_reg.page;
         end
         `ALN_ADR_CONV: begin
            rd_word[`ALN_CONV_W-1:0] = state_reg.conv;
         end
         `ALN_ADR_CLKCTRL: begin
            rd_word[`ALN_NIB_W-1:0] = state_reg.clk_ctrl;
         end
         `ALN_ADR_PTR: begin
            rd_word[`ALN_PTR_W-1:0] = state_reg.ptr;
         end
         `ALN_ADR_MEMDATA: begin
            rd_word[`ALN_NIB_W-1:0] = state_reg.mem[state_reg.ptr];
         end
         `ALN_ADR_STATUS: begin
            rd_word[`ALN_ST_UNKNOWN] = state_reg.unknown;
            rd_word[`ALN_ST_CARRY]   = state_reg.carry;
            rd_word[`ALN_ST_LASTOP_MSB:`ALN_ST_LASTOP_LSB] = state_reg.last_op;
         end
         `ALN_ADR_COUNT: begin
            rd_word[`ALN_CNT_W-1:0] = state_reg.count;
         end
         default: begin
            rd_word = `ALN_RST_DAT;
         end
      endcase
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      state_next = state_reg;

      // Ack is a single-cycle pulse; read data is captured with it
      state_next.ack = req;
      if (req && !WB_WE_I) begin
         state_next.dat = rd_word;
      end

      // Plain register writes, lane by lane
      if (wr) begin
         case (WB_ADR_I)
            `ALN_ADR_INSTR: begin
               state_next.instr = instr_merged;
            end
            `ALN_ADR_ACC: begin
               if (WB_SEL_I[0]) begin
                  state_next.acc = WB_DAT_I[`ALN_NIB_W-1:0];
               end
            end
            `ALN_ADR_PAGE: begin
               if (WB_SEL_I[0]) begin
                  state_next.page = WB_DAT_I[`ALN_NIB_W-1:0];
               end
            end
            `ALN_ADR_CONV: begin
               state_next.conv = (state_reg.conv & ~wr_mask[`ALN_CONV_W-1:0])
                               | (WB_DAT_I[`ALN_CONV_W-1:0] & wr_mask[`ALN_CONV_W-1:0]);
            end
            `ALN_ADR_CLKCTRL: begin
               if (WB_SEL_I[0]) begin
                  state_next.clk_ctrl = WB_DAT_I[`ALN_NIB_W-1:0];
               end
            end
            `ALN_ADR_PTR: begin
               if (WB_SEL_I[0]) begin
                  state_next.ptr = WB_DAT_I[`ALN_PTR_W-1:0];
               end
            end
            `ALN_ADR_MEMDATA: begin
               if (WB_SEL_I[0]) begin
                  state_next.mem[state_reg.ptr] = WB_DAT_I[`ALN_NIB_W-1:0];
               end
            end
            `ALN_ADR_STATUS: begin
               // Carry is software's; the instructions here never touch it
               if (WB_SEL_I[0]) begin
                  state_next.carry = WB_DAT_I[`ALN_ST_CARRY];
                  if (WB_DAT_I[`ALN_ST_UNKNOWN]) begin
                     state_next.unknown = 1'b0;
                  end
               end
            end
            `ALN_ADR_COUNT: begin
               if (WB_SEL_I[0]) begin
                  state_next.count = `ALN_RST_CNT;
               end
            end
            default: begin
               state_next.count = state_reg.count;
            end
         endcase
      end

      // Execution: one word, one cycle, carry and sequencing left alone
      if (instr_wr) begin
         state_next.last_op = dec_bus.op;
         case (dec_bus.op)
            aln_pkg::ALN_OP_CONV_LOW: begin
               // Two result bits left-aligned over cleared low bits
               state_next.acc = {state_reg.conv[1:0], `ALN_LOW_ZERO};
               state_next.count = `ALN_CNT_W'(state_reg.count + `ALN_CNT_ONE);
            end
            aln_pkg::ALN_OP_MEM_TOGGLE: begin
               state_next.acc  = state_reg.mem[state_reg.ptr];
               state_next.page = state_reg.page ^ dec_bus.imm;
               state_next.count = `ALN_CNT_W'(state_reg.count + `ALN_CNT_ONE);
            end
            aln_pkg::ALN_OP_CLK_READ: begin
               // Clock control is only read, never written back
               state_next.acc = state_reg.clk_ctrl;
               state_next.count = `ALN_CNT_W'(state_reg.count + `ALN_CNT_ONE);
            end
            default: begin
               // Set wins over a clear arriving in the same cycle
               state_next.unknown = 1'b1;
            end
         endcase
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   // Synchronous reset; the memory array is left uncleared to keep it cheap
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         state_reg.ack      <= 1'b0;
         state_reg.dat      <= `ALN_RST_DAT;
         state_reg.instr    <= `ALN_RST_INSTR;
         state_reg.acc      <= `ALN_RST_NIB;
         state_reg.page     <= `ALN_RST_NIB;
         state_reg.conv     <= `ALN_RST_CONV;
         state_reg.clk_ctrl <= `ALN_RST_NIB;
         state_reg.ptr      <= `ALN_RST_PTR;
         state_reg.carry    <= 1'b0;
         state_reg.unknown  <= 1'b0;
         state_reg.last_op  <= aln_pkg::ALN_OP_NONE;
         state_reg.count    <= `ALN_RST_CNT;
         state_reg.mem      <= state_reg.mem;
      end else begin
         state_reg <= state_next;
      end
   end

   // ***************************************************************
   // Outputs straight from flip-flops
   // ***************************************************************
   assign WB_DAT_O = state_reg.dat;
   assign WB_ACK_O = state_reg.ack;

endmodule

`default_nettype wire

// *** tb/aln_core_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "aln_defines.svh"

module aln_core_properties (
   input wire logic                  CORE_CLK,
   input wire logic                  NRST,
   input wire logic                  WB_CYC_I,
   input wire logic                  WB_STB_I,
   input wire logic                  WB_WE_I,
   input wire logic [`ALN_ADR_W-1:0] WB_ADR_I,
   input wire logic [`ALN_SEL_W-1:0] WB_SEL_I,
   input wire logic [`ALN_DAT_W-1:0] WB_DAT_I,
   input wire logic [`ALN_DAT_W-1:0] WB_DAT_O,
   input wire logic                  WB_ACK_O
);
   // ***************************************************************
   // Shadow of the visible nibble registers
   // ***************************************************************
   logic [3:0] acc_sh;
   logic [3:0] page_sh;
   logic [3:0] clk_sh;
   logic [1:0] conv_sh;
   logic       acc_ok;
   logic       wr;
   logic [9:0] iw;
   logic       rd;

   // Taken write with the low byte enabled
   assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0];
   assign iw = WB_DAT_I[9:0];
   assign rd = WB_ACK_O && !WB_WE_I;

   // Memory is not mirrored, so a memory load leaves the accumulator unchecked
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         acc_sh  <= 4'h0;
         page_sh <= 4'h0;
         clk_sh  <= 4'h0;
         conv_sh <= 2'h0;
         acc_ok  <= 1'h1;
      end else if (wr) begin
         case (WB_ADR_I)
            8'h00: begin
               if (iw == 10'h249) begin
                  acc_sh <= {conv_sh, 2'h0};
                  acc_ok <= 1'h1;
               end else if (iw == 10'h252) begin
                  acc_sh <= clk_sh;
                  acc_ok <= 1'h1;
               end else if (iw[9:4] == 6'h2c) begin
                  acc_ok  <= 1'h0;
                  page_sh <= page_sh ^ iw[3:0];
               end
            end
            8'h04: begin
               acc_sh <= WB_DAT_I[3:0];
               acc_ok <= 1'h1;
            end
            8'h08: page_sh <= WB_DAT_I[3:0];
            8'h0c: conv_sh <= WB_DAT_I[1:0];
            8'h10: clk_sh <= WB_DAT_I[3:0];
            default: ;
         endcase
      end
   end

   // ***************************************************************
   // Properties
   // ***************************************************************
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   property p_ack_timing;
      WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
   endproperty
   a_ack_timing: assert property (p_ack_timing) else $error("ack late");
   property p_ack_pulse;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_no_spur;
      !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O;
   endproperty
   a_no_spur: assert property (p_no_spur) else $error("ack without request");
   property p_rd_hold;
      !rd |-> $stable(WB_DAT_O);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_acc_model;
      rd && WB_ADR_I == 8'h04 && acc_ok |-> WB_DAT_O == {28'h0, acc_sh};
   endproperty
   a_acc_model: assert property (p_acc_model) else $error("acc wrong");
   property p_page_model;
      rd && WB_ADR_I == 8'h08 |-> WB_DAT_O[3:0] == page_sh;
   endproperty
   a_page_model: assert property (p_page_model) else $error("page wrong");
   property p_clk_kept;
      rd && WB_ADR_I == 8'h10 |-> WB_DAT_O[3:0] == clk_sh;
   endproperty
   a_clk_kept: assert property (p_clk_kept) else $error("clock control moved");

   c_conv: cover property (wr && WB_ADR_I == 8'h00 && iw == 10'h249);
   c_mem: cover property (wr && WB_ADR_I == 8'h00 && iw[9:4] == 6'h2c);
   c_clk: cover property (wr && WB_ADR_I == 8'h00 && iw == 10'h252);
endmodule

bind aln_core aln_core_properties u_props (.CORE_CLK(CORE_CLK), .NRST(NRST),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O));

`default_nettype wire

// *** tb/aln_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic        core_clk;
   logic        nrst;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat;
   logic [31:0] dat_o;
   logic        ack;
   int          bad_count;
   int          compares;

   aln_core DUT (.CORE_CLK(core_clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack));

   // ***************************************************************
   // Bus and check helpers
   // ***************************************************************
   task automatic final_report();
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask

   // One classic cycle; the wait is bounded so a dead slave ends the run
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'h1 && n < 20);
      q = dat_o;
      cyc <= 1'h0;
      stb <= 1'h0;
      if (ack !== 1'h1) begin
         chk("ack", 32'h1, 32'h0);
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, q);
      chk(nm, e, q);
   endtask

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_conv();
      for (int c = 0; c < 4; c++) begin
         wr(8'h0c, {22'h0, 8'hff, c[1:0]});
         wr(8'h04, 32'h3);
         wr(8'h00, 32'h249);
         rd(8'h04, {28'h0, c[1:0], 2'h0}, "acc_conv");
      end
   endtask

   // Every immediate; page keeps the running XOR
   task automatic t_mem();
      logic [3:0] pg;
      pg = 4'h5;
      wr(8'h08, 32'h5);
      for (int j = 0; j < 16; j++) begin
         wr(8'h14, {24'h0, j[3:0], j[3:0]});
         wr(8'h18, {28'h0, 4'hf - j[3:0]});
         wr(8'h00, {22'h0, 6'h2c, j[3:0]});
         pg = pg ^ j[3:0];
         rd(8'h04, {28'h0, 4'hf - j[3:0]}, "acc_mem");
         rd(8'h08, {28'h0, pg}, "page");
      end
      // Accumulator differs from the addressed memory word, so a false match shows
      wr(8'h04, 32'h9);
      wr(8'h00, 32'h0c3);
      rd(8'h08, {28'h0, pg}, "page_near_miss");
      rd(8'h04, 32'h9, "acc_near_miss");
   endtask

   // Instruction written without the low lane must not execute
   task automatic t_sel();
      wr(8'h10, 32'h5);
      wr(8'h04, 32'h9);
      sel <= 4'he;
      wr(8'h00, 32'h252);
      sel <= 4'hf;
      rd(8'h04, 32'h9, "acc_no_lane0");
   endtask

   // Reset in mid-run clears the visible registers
   task automatic t_rst();
      wr(8'h08, 32'h7);
      wr(8'h04, 32'h6);
      @(posedge core_clk);
      nrst <= 1'h0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'h1;
      rd(8'h04, 32'h0, "acc_rst");
      rd(8'h08, 32'h0, "page_rst");
      rd(8'h1c, 32'h0, "status_rst");
      rd(8'h20, 32'h0, "count_rst");
   endtask

   task automatic t_clk();
      wr(8'h10, 32'ha);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h252);
      rd(8'h04, 32'ha, "acc_clk");
      rd(8'h10, 32'ha, "clk_ctrl");
   endtask

   // Carry set, then three instructions back to back
   task automatic t_seq();
      wr(8'h1c, 32'h3);
      wr(8'h20, 32'h0);
      wr(8'h00, 32'h249);
      wr(8'h00, 32'h2c5);
      wr(8'h00, 32'h252);
      rd(8'h1c, 32'h32, "status");
      rd(8'h20, 32'h3, "count");
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40, 32'h0, "unmapped");
   endtask

   // Free-running core clock
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end

   // Reset, then the scenarios in order
   initial begin
      bad_count = 0;
      compares = 0;
      nrst = 1'h0;
      cyc = 1'h0;
      stb = 1'h0;
      we = 1'h0;
      adr = 8'h00;
      sel = 4'hf;
      dat = 32'h0;
      repeat (3) @(posedge core_clk);
      nrst <= 1'h1;
      t_conv();
      t_mem();
      t_clk();
      t_seq();
      t_sel();
      t_rst();
      final_report();
   end
endmodule

`default_nettype wire
